// *** dcp_map.vh ***
// Constants of the channel program interface: select codes, control word fields, I/O commands, FIFO size.
`ifndef DCP_MAP_VH
`define DCP_MAP_VH
`define DCP_CH1_LOW_SC 6'h02
`define DCP_CH2_LOW_SC 6'h03
`define DCP_CH1_HIGH_SC 6'h06
`define DCP_CH2_HIGH_SC 6'h07
`define DCP_CW_SC_MSB 5
`define DCP_CW_SC_LSB 0
`define DCP_CW_STC_BIT 15
`define DCP_CW_PACK_BIT 14
`define DCP_CW_CLC_BIT 13
`define DCP_MAR_DIR_BIT 15
`define DCP_CW_RESET 16'h0000
`define DCP_MAR_RESET 16'h0000
`define DCP_WCR_RESET 16'h0000
`define DCP_IO_OP_OUTPUT 3'h1
`define DCP_IO_OP_STC 3'h2
`define DCP_IO_OP_CLC 3'h3
`define DCP_IO_OP_STCC 3'h4
`define DCP_IO_OP_CLF 3'h5
`define DCP_FIFO_WIDTH 16
`define DCP_FIFO_DEPTH 8
`define DCP_FIFO_AW 3
`endif

// *** dcp_fifo.v ***
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module dcp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset.
   input wire clk_sys,
   input wire reset,
   // Filling side.
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Draining side.
   output wire out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] count_reg;
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg out_valid_reg;
   wire do_write;
   wire do_read;
   wire [AW:0] depth_w;

   assign depth_w = DEPTH[AW:0];
   assign in_ready = (count_reg != depth_w);
   assign do_write = in_valid && in_ready;
   // Output register is refilled when empty or being drained.
   assign do_read = (count_reg != {(AW+1){1'b0}}) && (!out_valid_reg || out_ready);
   assign out_valid = out_valid_reg;

   always @(posedge clk_sys) begin
      if (do_write) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         count_reg <= {(AW+1){1'b0}};
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         out_valid_reg <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else begin
         if (do_write) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_read) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
            out_data <= mem[rd_ptr_reg];
            out_valid_reg <= 1'b1;
         end else if (out_ready) begin
            out_valid_reg <= 1'b0;
         end
         if (do_write && !do_read) begin
            count_reg <= count_reg + 1'b1;
         end else if (!do_write && do_read) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // dcp_fifo

// *** dcp_channel.v ***
// One channel of the direct memory access program interface.
`timescale 1ns/100ps
`include "dcp_map.vh"
// Functional notes
// - Each channel instance runs fully independently; one or two may be fitted.
// - A channel serves exactly one peripheral on an ordinary I/O channel.
// - The peripheral is chosen only by the programmed control word.
// - The lower select code (2 or 3) reaches address and count registers.
// - Selector cleared by clear control: output to low code loads address.
// - Higher select code (6 or 7) takes control word and runs the channel.
// - Block completion sets the flag of the higher select code.
// - Flag raises interrupt when enabled; otherwise software polls with skip-if-flag-set.
// - Control word bits 5..0 hold the peripheral select code.
// - Bit 15 set: issue set-control-clear-flag to peripheral after every byte.
// - Bit 14 set: pack two 8-bit characters into each 16-bit word.
// - Bit 13 set: issue clear control to peripheral after the final byte.
// - Once started the channel completes the block without program help.
// - Set control to the lower code sets selector; next output loads count.
// - Address bit 15 selects direction: one input, zero output.
// - Set-control-clear-flag to higher code enables; service on each peripheral flag.
module dcp_channel #(
   parameter [5:0] LOW_SC = `DCP_CH1_LOW_SC,
   parameter [5:0] HIGH_SC = `DCP_CH1_HIGH_SC
) (
   // Clock and reset.
   input wire clk_sys,
   input wire reset,
   // Processor I/O instruction port.
   input wire [5:0] cpu_sc,
   input wire [2:0] cpu_op,
   input wire cpu_strobe,
   input wire [15:0] cpu_data,
   input wire int_enable,
   output reg flag_out,
   output reg irq_out,
   // Peripheral service request, from the flagged device.
   input wire [5:0] srq_sc,
   input wire srq,
   // Peripheral I/O command port.
   output reg [5:0] io_sc,
   output reg [2:0] io_op,
   output reg io_strobe,
   output reg [15:0] io_out_data,
   input wire [15:0] io_in_data,
   // Memory port.
   output reg mem_req,
   output reg mem_write,
   output reg [14:0] mem_addr,
   output reg [15:0] mem_wdata,
   input wire mem_ack,
   input wire [15:0] mem_rdata
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_WAIT = 2'h1;
   localparam [1:0] ST_MEM = 2'h2;
   localparam [1:0] ST_DONE = 2'h3;

   reg [15:0] cw_reg;
   reg [15:0] mar_reg;
   reg [15:0] wcr_reg;
   reg sel_reg;
   reg active_reg;
   reg [1:0] state_reg;
   reg half_reg;
   reg [7:0] hold_reg;
   reg fin_reg;
   // Words fetched for output that have not yet left towards the peripheral.
   reg [3:0] pend_reg;

   reg fifo_in_valid;
   reg [15:0] fifo_in_data;
   reg fifo_out_ready;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [15:0] fifo_out_data;

   // Decoded strobes and control word fields.
   wire low_hit;
   wire high_hit;
   wire dir_in;
   wire pack;
   wire last_word;
   wire dev_srq;

   function hit;
      input [5:0] sc;
      input [5:0] code;
      begin
         hit = cpu_strobe && (sc == code);
      end
   endfunction

   assign low_hit = hit(cpu_sc, LOW_SC);
   assign high_hit = hit(cpu_sc, HIGH_SC);
   assign dir_in = mar_reg[`DCP_MAR_DIR_BIT];
   assign pack = cw_reg[`DCP_CW_PACK_BIT];
   // The count runs up from its two's complement, so ffff marks the last word.
   assign last_word = (wcr_reg == 16'hffff);
   // Only the peripheral named in the control word is serviced.
   assign dev_srq = srq && (srq_sc == cw_reg[`DCP_CW_SC_MSB:`DCP_CW_SC_LSB]);

   ////////////////////////////////////////////////////////////////////////////
   // Words buffered between the peripheral and memory.
   // Output words are fetched ahead; input words pass through and leave at the write.
   dcp_fifo #(
      .WIDTH(`DCP_FIFO_WIDTH),
      .DEPTH(`DCP_FIFO_DEPTH),
      .AW(`DCP_FIFO_AW)
   ) u_fifo (
      .clk_sys(clk_sys),
      .reset(reset),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Programming through the two select codes.
   always @(posedge clk_sys) begin
      if (reset) begin
         cw_reg <= `DCP_CW_RESET;
         sel_reg <= 1'b0;
         flag_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         if (high_hit && cpu_op == `DCP_IO_OP_OUTPUT) begin
            cw_reg <= cpu_data;
         end
         if (low_hit && cpu_op == `DCP_IO_OP_CLC) begin
            sel_reg <= 1'b0;
         end else if (low_hit && (cpu_op == `DCP_IO_OP_STC || cpu_op == `DCP_IO_OP_STCC)) begin
            sel_reg <= 1'b1;
         end
         // Completion wins over a clear arriving in the same cycle.
         if (state_reg == ST_DONE) begin
            flag_out <= 1'b1;
         end else if (high_hit && (cpu_op == `DCP_IO_OP_CLF || cpu_op == `DCP_IO_OP_STCC)) begin
            flag_out <= 1'b0;
         end
         // The interrupt follows the flag and rises with it on completion.
         irq_out <= int_enable && (flag_out || state_reg == ST_DONE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine.
   // Each peripheral command is one strobe; the next service waits until that
   // strobe is gone, so the peripheral has had time to drop its flag.
   always @(posedge clk_sys) begin
      if (reset) begin
         mar_reg <= `DCP_MAR_RESET;
         wcr_reg <= `DCP_WCR_RESET;
         active_reg <= 1'b0;
         state_reg <= ST_IDLE;
         half_reg <= 1'b0;
         hold_reg <= 8'h00;
         fin_reg <= 1'b0;
         pend_reg <= 4'h0;
         io_sc <= 6'h00;
         io_op <= 3'h0;
         io_strobe <= 1'b0;
         io_out_data <= 16'h0000;
         mem_req <= 1'b0;
         mem_write <= 1'b0;
         mem_addr <= 15'h0000;
         mem_wdata <= 16'h0000;
         fifo_in_valid <= 1'b0;
         fifo_in_data <= 16'h0000;
         fifo_out_ready <= 1'b0;
      end else begin
         io_strobe <= 1'b0;
         fifo_in_valid <= 1'b0;
         fifo_out_ready <= 1'b0;
         io_sc <= cw_reg[`DCP_CW_SC_MSB:`DCP_CW_SC_LSB];
         // Address and count are refused while a block is running.
         if (low_hit && cpu_op == `DCP_IO_OP_OUTPUT && !active_reg) begin
            if (sel_reg) begin
               wcr_reg <= cpu_data;
            end else begin
               mar_reg <= cpu_data;
            end
         end
         case (state_reg)
            ST_IDLE: begin
               half_reg <= 1'b0;
               fin_reg <= 1'b0;
               pend_reg <= 4'h0;
               if (high_hit && cpu_op == `DCP_IO_OP_STCC) begin
                  active_reg <= 1'b1;
                  state_reg <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               // A strobe still on the wires means the flag seen now is stale;
               // no service or completion starts until the flag has had a cycle to drop.
               // Direction in: peripheral byte or word enters the buffer.
               if (dir_in && dev_srq && fifo_in_ready && !fin_reg && !io_strobe) begin
                  io_strobe <= 1'b1;
                  io_op <= cw_reg[`DCP_CW_STC_BIT] ? `DCP_IO_OP_STCC : `DCP_IO_OP_CLF;
                  if (pack && !half_reg) begin
                     hold_reg <= io_in_data[7:0];
                     half_reg <= 1'b1;
                  end else begin
                     fifo_in_valid <= 1'b1;
                     fifo_in_data <= pack ? {hold_reg, io_in_data[7:0]} : io_in_data;
                     half_reg <= 1'b0;
                     state_reg <= ST_MEM;
                  end
               end else if (!dir_in && dev_srq && fifo_out_valid && !io_strobe) begin
                  io_strobe <= 1'b1;
                  io_op <= `DCP_IO_OP_OUTPUT;
                  if (pack && !half_reg) begin
                     io_out_data <= {8'h00, fifo_out_data[15:8]};
                     half_reg <= 1'b1;
                  end else begin
                     io_out_data <= pack ? {8'h00, fifo_out_data[7:0]} : fifo_out_data;
                     fifo_out_ready <= 1'b1;
                     pend_reg <= pend_reg - 4'h1;
                     half_reg <= 1'b0;
                  end
               end else if (!dir_in && fin_reg && pend_reg == 4'h0 && !io_strobe) begin
                  // Last word has left and its trailing command has been issued.
                  state_reg <= ST_DONE;
               end else if (!dir_in && !fin_reg && fifo_in_ready && !fifo_out_valid) begin
                  state_reg <= ST_MEM;
               end
               // Follow each output with the control command from bit 15.
               if (io_strobe && io_op == `DCP_IO_OP_OUTPUT) begin
                  io_strobe <= 1'b1;
                  io_op <= cw_reg[`DCP_CW_STC_BIT] ? `DCP_IO_OP_STCC : `DCP_IO_OP_CLF;
               end
            end
            // One memory word per cycle request, held until acknowledged.
            ST_MEM: begin
               mem_req <= 1'b1;
               mem_write <= dir_in;
               mem_addr <= mar_reg[14:0];
               mem_wdata <= fifo_in_data;
               if (mem_req && mem_ack) begin
                  mem_req <= 1'b0;
                  mar_reg <= {mar_reg[15], mar_reg[14:0] + 15'h0001};
                  wcr_reg <= wcr_reg + 16'h0001;
                  if (!dir_in) begin
                     fifo_in_valid <= 1'b1;
                     fifo_in_data <= mem_rdata;
                     pend_reg <= pend_reg + 4'h1;
                  end else begin
                     // The written word leaves the buffer, so none is left for a later block.
                     fifo_out_ready <= 1'b1;
                  end
                  fin_reg <= last_word;
                  state_reg <= (dir_in && last_word) ? ST_DONE : ST_WAIT;
               end
            end
            // Block complete: the flag is set by the programming logic.
            ST_DONE: begin
               active_reg <= 1'b0;
               state_reg <= ST_IDLE;
               if (cw_reg[`DCP_CW_CLC_BIT]) begin
                  io_strobe <= 1'b1;
                  io_op <= `DCP_IO_OP_CLC;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end
   // Each channel is instanced separately, so two never share state.
endmodule // dcp_channel

// *** dcp_chk_asserts.sv ***
// Port checker of one channel, bound to the channel module.
`timescale 1ns/100ps
`include "dcp_map.vh"
module dcp_chk #(
   parameter [5:0] HIGH_SC = 6'h06
) (
   // Clock and reset.
   input wire clk_sys,
   input wire reset,
   // Processor side.
   input wire [5:0] cpu_sc,
   input wire [2:0] cpu_op,
   input wire cpu_strobe,
   input wire [15:0] cpu_data,
   input wire int_enable,
   input wire flag_out,
   input wire irq_out,
   // Peripheral and memory side.
   input wire [5:0] io_sc,
   input wire [2:0] io_op,
   input wire io_strobe,
   input wire mem_req,
   input wire [14:0] mem_addr,
   input wire mem_ack
);
   wire hi = cpu_strobe && cpu_sc == HIGH_SC;
   wire cw_wr = hi && cpu_op == `DCP_IO_OP_OUTPUT;
   wire hi_clf = hi && cpu_op == `DCP_IO_OP_CLF;
   wire hi_clr = hi_clf || (hi && cpu_op == `DCP_IO_OP_STCC);
   reg [15:0] cw_reg;
   always @(posedge clk_sys) begin
      if (reset)
         cw_reg <= 16'h0000;
      else if (cw_wr)
         cw_reg <= cpu_data;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   sc_load_a: assert property (cw_wr |-> ##2 io_sc == $past(cpu_data[5:0], 2))
      else $error("code not loaded");
   io_code_a: assert property (io_strobe |-> io_sc == cw_reg[5:0])
      else $error("wrong peripheral");
   per_byte_a: assert property (io_strobe && io_op == `DCP_IO_OP_STCC |-> cw_reg[15])
      else $error("unasked set control");
   end_clear_a: assert property (io_strobe && io_op == `DCP_IO_OP_CLC |-> cw_reg[13])
      else $error("unasked clear control");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("request dropped");
   irq_follow_a: assert property
      (irq_out == ($past(int_enable) && ($past(flag_out) || flag_out)))
      else $error("interrupt wrong");
   flag_hold_a: assert property (flag_out && !hi_clr |=> flag_out)
      else $error("flag lost");
   flag_clear_a: assert property (hi_clf && flag_out |=> !flag_out)
      else $error("flag not cleared");
   cover property ($rose(flag_out));
   cover property (io_strobe && io_op == `DCP_IO_OP_STCC);
   cover property (io_strobe && io_op == `DCP_IO_OP_OUTPUT);
endmodule // dcp_chk
bind dcp_channel dcp_chk #(.HIGH_SC(HIGH_SC)) u_chk (.clk_sys(clk_sys), .reset(reset),
   .cpu_sc(cpu_sc), .cpu_op(cpu_op), .cpu_strobe(cpu_strobe), .cpu_data(cpu_data),
   .int_enable(int_enable), .flag_out(flag_out), .irq_out(irq_out), .io_sc(io_sc),
   .io_op(io_op), .io_strobe(io_strobe), .mem_req(mem_req), .mem_addr(mem_addr),
   .mem_ack(mem_ack));

// *** dcp_per.sv ***
// Peripheral card model serving one channel.
`timescale 1ns/100ps
`include "dcp_map.vh"
module dcp_per (
   // Clock, start pulse, own code and first data word.
   input wire clk_sys,
   input wire go,
   input wire [5:0] code,
   input wire [15:0] base,
   // Commands from the channel.
   input wire [5:0] io_sc,
   input wire [2:0] io_op,
   input wire io_strobe,
   input wire [15:0] io_out_data,
   // Request and data to the channel.
   output wire srq,
   output wire [5:0] srq_sc,
   output wire [15:0] io_in_data
);
   reg flag_reg = 1'b0;
   reg [2:0] wait_reg = 3'h0;
   reg [15:0] cur_reg = 16'h0000;
   reg [15:0] obuf [0:15];
   integer n_stcc = 0, n_clc = 0, n_out = 0;
   wire hit = io_strobe && io_sc == code;
   wire done = io_op == `DCP_IO_OP_STCC || io_op == `DCP_IO_OP_CLF;
   assign srq = flag_reg;
   assign srq_sc = flag_reg ? code : ~code;
   // Data is held only while flagged or strobed, so a late sample sees garbage.
   assign io_in_data = (flag_reg || hit) ? cur_reg : ~cur_reg;
   always @(negedge clk_sys) begin
      if (go) begin
         flag_reg <= 1'b1;
         cur_reg <= base;
         wait_reg <= 3'h0;
         n_stcc <= 0;
         n_clc <= 0;
         n_out <= 0;
      end else if (hit) begin
         if (io_op == `DCP_IO_OP_OUTPUT) obuf[n_out] <= io_out_data;
         n_out <= n_out + (io_op == `DCP_IO_OP_OUTPUT);
         n_stcc <= n_stcc + (io_op == `DCP_IO_OP_STCC);
         n_clc <= n_clc + (io_op == `DCP_IO_OP_CLC);
         flag_reg <= flag_reg && !done;
         if (done) wait_reg <= 3'(1 + $urandom % 4);
      end else if (!flag_reg && wait_reg != 3'h0) begin
         wait_reg <= wait_reg - 3'h1;
         flag_reg <= wait_reg == 3'h1;
         if (wait_reg == 3'h1) cur_reg <= cur_reg + 16'h1357;
      end
   end
endmodule // dcp_per

// *** dma_channel_program_interface_tb.sv ***
// Self-checking bench of one channel with peripheral and memory models.
`timescale 1ns/100ps
`include "dcp_map.vh"
module dma_channel_program_interface_tb;
   localparam [5:0] HI = `DCP_CH1_HIGH_SC;
   localparam [5:0] LO = `DCP_CH1_LOW_SC;
   reg clk_sys = 1'b0, reset = 1'b1, cpu_strobe = 1'b0, int_enable = 1'b0, go = 1'b0;
   reg mem_ack = 1'b0;
   reg [5:0] cpu_sc = 6'h00, code = 6'h00;
   reg [2:0] cpu_op = 3'h0;
   reg [15:0] cpu_data = 16'h0000, base = 16'h0000, mem_rdata = 16'h0000, cw, addr, w, b0, b1;
   reg [15:0] mem [0:255];
   wire flag_out, irq_out, srq, io_strobe, mem_req, mem_write;
   wire [5:0] srq_sc, io_sc;
   wire [2:0] io_op;
   wire [14:0] mem_addr;
   wire [15:0] io_out_data, io_in_data, mem_wdata;
   integer failures = 0, n_compared = 0, stall = 0, m, i, n, nb;
   always #5 clk_sys = ~clk_sys;
   dcp_channel u_dut (.clk_sys(clk_sys), .reset(reset), .cpu_sc(cpu_sc), .cpu_op(cpu_op),
      .cpu_strobe(cpu_strobe), .cpu_data(cpu_data), .int_enable(int_enable),
      .flag_out(flag_out), .irq_out(irq_out), .srq_sc(srq_sc), .srq(srq), .io_sc(io_sc),
      .io_op(io_op), .io_strobe(io_strobe), .io_out_data(io_out_data), .io_in_data(io_in_data),
      .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   dcp_per u_per (.clk_sys(clk_sys), .go(go), .code(code), .base(base), .io_sc(io_sc),
      .io_op(io_op), .io_strobe(io_strobe), .io_out_data(io_out_data), .srq(srq),
      .srq_sc(srq_sc), .io_in_data(io_in_data));
   // Memory answers after a random stall; read data is not held past the answer.
   always @(negedge clk_sys) begin
      if (stall == 0 && mem_req && !mem_ack) begin
         mem_ack <= 1'b1;
         stall <= $urandom % 3;
         if (mem_write) mem[mem_addr[7:0]] <= mem_wdata;
         mem_rdata <= mem_write ? ~mem_rdata : mem[mem_addr[7:0]];
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         stall <= (stall > 0) ? stall - 1 : 0;
      end
   end
   function [15:0] byt(input integer k);
      byt = base + 16'(k) * 16'h1357;
   endfunction
   task cpu(input [5:0] sc, input [2:0] op, input [15:0] d);
      begin
         @(negedge clk_sys);
         cpu_sc = sc;
         cpu_op = op;
         cpu_data = d;
         cpu_strobe = 1'b1;
         @(negedge clk_sys);
         cpu_strobe = 1'b0;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("compared %0d failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      #400000;
      failures = failures + 1;
      finish_test;
   end
   initial begin
      i = $urandom(41);
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      reset = 1'b0;
      // Modes: input and output, each with and without packing.
      for (m = 0; m < 4; m = m + 1) begin
         @(negedge clk_sys);
         n = 1 + $urandom % 3;
         nb = m[1] ? 2 * n : n;
         addr = 16'(16 + m * 32 + $urandom % 8);
         code = 6'(16 + m);
         base = $urandom;
         int_enable <= m[0] ^ m[1];
         cw = {1'($urandom), m[1], 1'($urandom), 7'h00, code};
         for (i = 0; i < 16; i = i + 1) mem[addr[7:0] + i] = 16'ha5c3 ^ 16'(i * 257);
         cpu(HI, `DCP_IO_OP_OUTPUT, cw);
         cpu(LO, `DCP_IO_OP_CLC, 16'h0000);
         cpu(LO, `DCP_IO_OP_OUTPUT, {m[0], addr[14:0]});
         cpu(LO, `DCP_IO_OP_STC, 16'h0000);
         cpu(LO, `DCP_IO_OP_OUTPUT, 16'h0000 - 16'(n));
         go <= 1'b1;
         @(negedge clk_sys);
         go <= 1'b0;
         cpu(HI, `DCP_IO_OP_STCC, 16'h0000);
         for (i = 0; i < 3000 && flag_out !== 1'b1; i = i + 1) @(negedge clk_sys);
         repeat (4) @(negedge clk_sys);
         chk(flag_out, 1'b1);
         chk(irq_out, int_enable);
         chk(16'(u_per.n_stcc), cw[15] ? 16'(nb) : 16'h0000);
         chk(16'(u_per.n_clc), {15'h0000, cw[13]});
         for (i = 0; i <= n; i = i + 1) begin
            w = 16'ha5c3 ^ 16'(i * 257);
            b0 = byt(2 * i);
            b1 = byt(2 * i + 1);
            if (m[0] && i < n) w = m[1] ? {b0[7:0], b1[7:0]} : byt(i);
            chk(mem[addr[7:0] + i], w);
            if (!m[0] && i < n && m[1]) begin
               chk(u_per.obuf[2 * i] & 16'h00ff, {8'h00, w[15:8]});
               chk(u_per.obuf[2 * i + 1] & 16'h00ff, {8'h00, w[7:0]});
            end else if (!m[0] && i < n)
               chk(u_per.obuf[i], w);
         end
         cpu(HI, `DCP_IO_OP_CLF, 16'h0000);
         @(negedge clk_sys);
         chk(flag_out, 1'b0);
      end
      finish_test;
   end
endmodule // dma_channel_program_interface_tb
